//--- hdl/radio_cm_pkg.sv
/*
  Constants for the control-monitor timing and I/O block: clock
  divisions, pulse widths, register offsets and field positions.
  Assumes a 50 MHz system clock; every derived rate is an enable.
*/
package radio_cm_pkg;

  // system clock and the emulated crystal
  localparam int CLK_KHZ = 50000;
  localparam int XTAL_KHZ = 3840;
  localparam int SYS_KHZ = XTAL_KHZ / 2;
  localparam int SYS_HZ = SYS_KHZ * 1000;
  localparam logic [15:0] ACC_STEP = 16'(XTAL_KHZ);
  localparam logic [15:0] ACC_MOD = 16'(CLK_KHZ);

  // square-wave rates
  localparam int CLK320_KHZ = 320;
  localparam int CLK640_HZ = 640;
  localparam int TONE_ONE_HZ = 2560;
  localparam int TONE_ZERO_HZ = 3200;
  localparam logic [1:0] HALF320_LAST = 2'(SYS_KHZ / (2 * CLK320_KHZ) - 1);
  localparam logic [10:0] HALF640_LAST = 11'(SYS_HZ / (2 * CLK640_HZ) - 1);
  localparam logic [8:0] TONE_ONE_LAST = 9'(SYS_HZ / (2 * TONE_ONE_HZ) - 1);
  localparam logic [8:0] TONE_ZERO_LAST = 9'(SYS_HZ / (2 * TONE_ZERO_HZ) - 1);

  // pulse times as printed, counts rounded to nearest 1.92 MHz cycle
  localparam int XFER_WIDTH_NS = 1500;
  localparam int XFER_PERIOD_US = 1560;
  localparam int MEMREQ_NS = 3400;
  localparam int TPULSE_NS = 500;
  localparam int STATE_NS = 8300;
  localparam int CLEAR_MS = 1000;
  localparam int XFER_WIDTH_CYC = (XFER_WIDTH_NS * SYS_KHZ + 500000) / 1000000;
  localparam int XFER_PERIOD_CYC = (XFER_PERIOD_US * SYS_KHZ + 500) / 1000;
  localparam int MEMREQ_CYC = (MEMREQ_NS * SYS_KHZ + 500000) / 1000000;
  localparam int TPULSE_CYC = (TPULSE_NS * SYS_KHZ + 500000) / 1000000;
  localparam int STATE_CYC = (STATE_NS * SYS_KHZ + 500000) / 1000000;
  localparam int CLEAR_CYC = CLEAR_MS * SYS_KHZ;

  localparam logic [11:0] FRAME_LAST = 12'(XFER_PERIOD_CYC - 1);
  localparam logic [11:0] XFER_W = 12'(XFER_WIDTH_CYC);
  localparam logic [11:0] STATE_W = 12'(STATE_CYC);
  localparam logic [3:0] SLOT_LAST = 4'(STATE_CYC - 1);
  localparam logic [1:0] STB_LAST = 2'(XFER_WIDTH_CYC - 1);
  localparam logic [3:0] MEMREQ_W = 4'(MEMREQ_CYC);
  localparam logic [3:0] MEMREQ_LAST = 4'(2 * MEMREQ_CYC - 1);
  localparam logic [3:0] DISP_BITS = 4'h8;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DISPLAY = 8'h08;
  localparam logic [7:0] ADDR_RADIO = 8'h0C;
  localparam logic [7:0] ADDR_SWITCH = 8'h10;
  localparam logic [7:0] ADDR_BUS = 8'h14;
  localparam logic [7:0] ADDR_STROBE = 8'h18;

  // control field positions and reset values
  localparam int CTRL_TX = 0;
  localparam int CTRL_TONE = 1;
  localparam int CTRL_PROMO = 2;
  localparam int CTRL_MEMREQ = 3;
  localparam int CTRL_STATE0 = 4;
  localparam int CTRL_DRIVE = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [7:0] RADIO_RST = 8'h00;

  typedef enum logic {DISP_IDLE = 1'b0, DISP_SHIFT = 1'b1} disp_state_t;

endpackage

//--- hdl/radio_cm_timing.sv
/*
  Timing and I/O unit of the control-monitor: clock generation,
  power-on clear, strobes, tone and tandem serial lines, display
  shifter, panel switch sampling and an AHB-Lite register slave.
  Assumes one 50 MHz clock, a synchronous reset, and that pins from
  outside arrive asynchronous; bus pin tri-state is resolved outside.
*/
// How it works
// [R1] radio tones are frequency-shifted around 2880 Hz using 2560 and 3200 Hz
// [R2] a one sends the 2560 Hz square wave, a zero the 3200 Hz one
// [R3] tandem data is a serial stream clocked at 640 Hz
// [R4] display gets serial data with a 320 kHz shift clock
// [R5] outputs 1.92 MHz, 320 kHz and 640 Hz square waves
// [R6] active-low clear held low one second after power-up, then high
// [R7] transfer tick: 1.5 us low pulse every 1.56 ms
// [R8] latch strobe is a 1.5 us high pulse
// [R9] carrier detect low while tone data comes from a radio
// [R10] demodulated radio data is passed on as a 640 Hz stream
// [R11] serial transmit line goes high when tone data is sent
// [R12] tandem data leaves on serial transmit line, arrives on tandem input
// [R13] memory request is a train of 3.4 us low pulses while enabled
// [R14] two timing pulse trains with 0.5 us high pulses
// [R15] second state bit high 8.3 us once every 1.56 ms
// [R16] first state bit holds its level for 8.3 us intervals
// [R17] an eight-line two-way data bus carries radio data
// [R18] front-panel switches are sampled and shown to software
// [R19] backup role only monitors radio settings but may ask promotion
// [R20] primary role may change frequency, mode and channel
// [R21] 1.92 MHz comes from halving 3.84 MHz; lower clocks divide it
// [R22] serial transmit line is turned into the square-wave tone
// [R23] widths and periods count 1.92 MHz cycles, rounded to nearest
// [R24] clear release is aligned to a 1.92 MHz edge
`timescale 1ns/10ps
module radio_cm_timing
  import radio_cm_pkg::*;
#(
  parameter int CLEAR_TICKS = CLEAR_CYC
)
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic carrier_detect_n_i,
  input wire logic radio_rx_data_i,
  input wire logic tandem_rx_data_i,
  input wire logic main_standby_i,
  input wire logic [7:0] panel_switch_i,
  input wire logic [7:0] dbus_i,
  output logic [7:0] dbus_o,
  output logic dbus_oe_n_o,
  output logic clk_1m92_o,
  output logic clk_320k_o,
  output logic clk_640_o,
  output logic power_on_clear_n_o,
  output logic transfer_tick_n_o,
  output logic latch_strobe_o,
  output logic [2:0] select_code_bits_o,
  output logic mem_request_n_o,
  output logic timing_pulse_a_o,
  output logic timing_pulse_b_o,
  output logic state_code0_o,
  output logic state_code1_o,
  output logic display_data_o,
  output logic display_clk_o,
  output logic serial_tx_line_o,
  output logic tone_tx_data_o,
  output logic promote_req_o
);

  typedef struct packed {
    logic [15:0] acc;
    logic c192;
    logic tick;
    logic [1:0] d320;
    logic c320;
    logic [10:0] d640;
    logic c640;
    logic [11:0] frame;
    logic [20:0] clr_cnt;
    logic power_on_clear_n;
    logic [3:0] slot;
    logic [3:0] mr_cnt;
    logic mr_n;
    logic ta;
    logic tb;
    logic sc0;
    logic sc1;
    logic xfer_n;
    logic stb_req;
    logic [1:0] stb_cnt;
    logic stb;
    logic [2:0] code;
    logic [2:0] code_out;
    logic [5:0] ctrl;
    logic [7:0] radio;
    logic [7:0] disp_sr;
    logic [3:0] disp_bits;
    disp_state_t disp;
    logic disp_do;
    logic txl;
    logic [8:0] tone_cnt;
    logic tone;
    logic [3:0] m1;
    logic [3:0] m2;
    logic [7:0] sw1;
    logic [7:0] sw2;
    logic [7:0] sw_cap;
    logic [7:0] bus1;
    logic [7:0] bus2;
    logic drv_n;
    logic prom;
    logic pend;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] rdata;
    logic ready;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic [16:0] acc_sum;
  logic ovf;
  logic w320;
  logic w640;
  logic primary;

  // 3.84 MHz rate from a fractional accumulator: average exact, jitter
  // of one system clock is the price of a 50 MHz source
  always_comb
  begin
    acc_sum = {1'b0, st_reg.acc} + {1'b0, ACC_STEP};
    ovf = acc_sum >= {1'b0, ACC_MOD};
    w320 = st_reg.tick && (st_reg.d320 == HALF320_LAST);
    w640 = st_reg.tick && (st_reg.d640 == HALF640_LAST);
    primary = st_reg.m2[3];
    st_next = st_reg;
    st_next.acc = ovf ? 16'(acc_sum - {1'b0, ACC_MOD}) : acc_sum[15:0];
    st_next.c192 = st_reg.c192 ^ ovf; // see [R21]
    st_next.tick = ovf && !st_reg.c192; // see [R23]

    // input synchronisers; first stage feeds only the second
    st_next.m1 = {main_standby_i, tandem_rx_data_i, radio_rx_data_i,
                  carrier_detect_n_i};
    st_next.m2 = st_reg.m1; // see [R9]
    st_next.sw1 = panel_switch_i;
    st_next.sw2 = st_reg.sw1;
    st_next.bus1 = dbus_i;
    st_next.bus2 = st_reg.bus1;

    // everything below advances once per 1.92 MHz cycle
    if (st_reg.tick)
    begin
      st_next.d320 = w320 ? 2'h0 : st_reg.d320 + 2'h1;
      st_next.c320 = st_reg.c320 ^ w320; // see [R5]
      st_next.ta = w320 && !st_reg.c320; // see [R14]
      st_next.tb = w320 && st_reg.c320; // see [R14]
      st_next.d640 = w640 ? 11'h000 : st_reg.d640 + 11'h001;
      st_next.c640 = st_reg.c640 ^ w640; // see [R5]
      st_next.frame = (st_reg.frame == FRAME_LAST) ? 12'h000 :
                      st_reg.frame + 12'h001;
      st_next.xfer_n = st_next.frame >= XFER_W; // see [R7]
      st_next.sc1 = st_next.frame < STATE_W; // see [R15]
      st_next.slot = (st_reg.slot == SLOT_LAST) ? 4'h0 :
                     st_reg.slot + 4'h1;
      if (st_next.slot == 4'h0)
      begin
        st_next.sc0 = st_reg.ctrl[CTRL_STATE0]; // see [R16]
      end

      // clear released on a 1.92 MHz edge after the count
      if (!st_reg.power_on_clear_n)
      begin
        if (st_reg.clr_cnt == 21'(CLEAR_TICKS - 1))
        begin
          st_next.power_on_clear_n = 1'b1; // see [R6] and [R24]
        end
        else
        begin
          st_next.clr_cnt = st_reg.clr_cnt + 21'h000001;
        end
      end

      // memory request: low half then high half of each period
      st_next.mr_cnt = (st_reg.mr_cnt == MEMREQ_LAST) ? 4'h0 :
                       st_reg.mr_cnt + 4'h1;
      st_next.mr_n = st_next.mr_cnt >= MEMREQ_W; // see [R13]

      // latch strobe with select code, one shot per request
      if (st_reg.stb)
      begin
        if (st_reg.stb_cnt == 2'h0)
        begin
          st_next.stb = 1'b0;
          st_next.code_out = 3'h0;
        end
        else
        begin
          st_next.stb_cnt = st_reg.stb_cnt - 2'h1;
        end
      end
      else if (st_reg.stb_req)
      begin
        st_next.stb = 1'b1; // see [R8]
        st_next.code_out = st_reg.code;
        st_next.stb_cnt = STB_LAST;
        st_next.stb_req = 1'b0;
      end

      // tx line moves only on the 640 Hz rising edge
      if (w640 && !st_reg.c640)
      begin
        st_next.txl = st_reg.ctrl[CTRL_TX]; // see [R3], [R11] and [R12]
        st_next.sw_cap = st_reg.sw2; // see [R18]
      end

      // tone half period chosen by the tx line level
      if (st_reg.ctrl[CTRL_TONE])
      begin
        if (st_reg.tone_cnt >= (st_reg.txl ? TONE_ONE_LAST : TONE_ZERO_LAST))
        begin
          st_next.tone_cnt = 9'h000;
          st_next.tone = !st_reg.tone; // see [R1], [R2] and [R22]
        end
        else
        begin
          st_next.tone_cnt = st_reg.tone_cnt + 9'h001;
        end
      end

      // display shifter: data changes as the 320 kHz clock falls
      if (w320 && st_reg.c320)
      begin
        case (st_reg.disp)
          DISP_IDLE:
          begin
            st_next.disp_do = 1'b0;
          end
          DISP_SHIFT:
          begin
            if (st_reg.disp_bits == 4'h0)
            begin
              st_next.disp = DISP_IDLE;
              st_next.disp_do = 1'b0;
            end
            else
            begin
              st_next.disp_do = st_reg.disp_sr[7]; // see [R4]
              st_next.disp_sr = {st_reg.disp_sr[6:0], 1'b0};
              st_next.disp_bits = st_reg.disp_bits - 4'h1;
            end
          end
          default:
          begin
            st_next.disp = DISP_IDLE;
          end
        endcase
      end
    end

    // disabling stops a train or tone at once, not at the next tick
    // parked at the last count so the first enabled tick opens a full
    // low pulse instead of a short one
    if (!st_reg.ctrl[CTRL_MEMREQ])
    begin
      st_next.mr_cnt = MEMREQ_LAST;
      st_next.mr_n = 1'b1;
    end
    if (!st_reg.ctrl[CTRL_TONE])
    begin
      st_next.tone_cnt = 9'h000;
      st_next.tone = 1'b0;
    end
    st_next.drv_n = !(st_reg.ctrl[CTRL_DRIVE] && primary); // see [R17]
    st_next.prom = st_reg.ctrl[CTRL_PROMO] && !primary; // see [R19]

    // bus slave: one wait cycle, so read data leaves a flop
    st_next.ready = 1'b1;
    st_next.pend = 1'b0;
    if (hsel_i && htrans_i[1] && hready_i && !st_reg.pend)
    begin
      st_next.pend = 1'b1;
      st_next.ready = 1'b0;
      st_next.a_wr = hwrite_i;
      st_next.a_addr = haddr_i[7:0];
    end
    if (st_reg.pend)
    begin
      st_next.rdata = 32'h00000000;
      if (st_reg.a_wr)
      begin
        case (st_reg.a_addr)
          ADDR_CTRL:
          begin
            st_next.ctrl = hwdata_i[5:0];
          end
          ADDR_DISPLAY:
          begin
            // a load during a shift is dropped; poll busy first
            if (st_reg.disp == DISP_IDLE)
            begin
              st_next.disp_sr = hwdata_i[7:0];
              st_next.disp_bits = DISP_BITS;
              st_next.disp = DISP_SHIFT;
            end
          end
          ADDR_RADIO:
          begin
            if (primary)
            begin
              st_next.radio = hwdata_i[7:0]; // see [R19] and [R20]
            end
          end
          ADDR_STROBE:
          begin
            st_next.code = hwdata_i[2:0];
            st_next.stb_req = 1'b1;
          end
          default:
          begin
            st_next.rdata = 32'h00000000;
          end
        endcase
      end
      else
      begin
        case (st_reg.a_addr)
          ADDR_CTRL: st_next.rdata = {26'h0000000, st_reg.ctrl};
          ADDR_STATUS: st_next.rdata = {25'h0000000, st_reg.c640,
            (st_reg.disp == DISP_SHIFT), st_reg.power_on_clear_n, st_reg.m2}; // see [R10]
          ADDR_DISPLAY: st_next.rdata = {24'h000000, st_reg.disp_sr};
          ADDR_RADIO: st_next.rdata = {24'h000000, st_reg.radio};
          ADDR_SWITCH: st_next.rdata = {24'h000000, st_reg.sw_cap};
          ADDR_BUS: st_next.rdata = {24'h000000, st_reg.bus2};
          ADDR_STROBE: st_next.rdata = {29'h00000000, st_reg.code};
          default: st_next.rdata = 32'h00000000;
        endcase
      end
    end
  end

  // single register stage for all state
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      st_reg <= '0;
      st_reg.xfer_n <= 1'b1;
      st_reg.frame <= FRAME_LAST; // first tick opens a whole frame
      st_reg.mr_n <= 1'b1;
      st_reg.drv_n <= 1'b1;
      st_reg.ready <= 1'b1;
      st_reg.ctrl <= CTRL_RST;
      st_reg.radio <= RADIO_RST;
      st_reg.disp <= DISP_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign hrdata_o = st_reg.rdata;
  assign hreadyout_o = st_reg.ready;
  assign hresp_o = 1'b0; // always OKAY
  assign dbus_o = st_reg.radio;
  assign dbus_oe_n_o = st_reg.drv_n;
  assign clk_1m92_o = st_reg.c192;
  assign clk_320k_o = st_reg.c320;
  assign clk_640_o = st_reg.c640;
  assign power_on_clear_n_o = st_reg.power_on_clear_n;
  assign transfer_tick_n_o = st_reg.xfer_n;
  assign latch_strobe_o = st_reg.stb;
  assign select_code_bits_o = st_reg.code_out;
  assign mem_request_n_o = st_reg.mr_n;
  assign timing_pulse_a_o = st_reg.ta;
  assign timing_pulse_b_o = st_reg.tb;
  assign state_code0_o = st_reg.sc0;
  assign state_code1_o = st_reg.sc1;
  assign display_data_o = st_reg.disp_do;
  assign display_clk_o = st_reg.c320;
  assign serial_tx_line_o = st_reg.txl;
  assign tone_tx_data_o = st_reg.tone;
  assign promote_req_o = st_reg.prom;

  // helper: system clocks spent with the transfer tick low
  logic [7:0] low_len_reg;
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || transfer_tick_n_o)
    begin
      low_len_reg <= 8'h00;
    end
    else
    begin
      low_len_reg <= low_len_reg + 8'h01;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  a_clear_release: assert property ( // see [R24]
    $rose(power_on_clear_n_o) |->
      $past(st_reg.tick) && $past(st_reg.clr_cnt) == 21'(CLEAR_TICKS - 1))
    else $error("clear released off the count or off a tick");

  a_tick_width: assert property ( // see [R7]
    $rose(transfer_tick_n_o) |-> low_len_reg >= 8'h4D && low_len_reg <= 8'h51)
    else $error("transfer tick low width wrong");

  a_state1_frame: assert property ( // see [R15]
    $rose(state_code1_o) |-> st_reg.frame == 12'h000 && !transfer_tick_n_o)
    else $error("state bit not aligned to frame start");

  a_tone_half: assert property ( // see [R2]
    $changed(tone_tx_data_o) && $past(st_reg.ctrl[CTRL_TONE]) |->
      $past(st_reg.tone_cnt) >=
        ($past(st_reg.txl) ? TONE_ONE_LAST : TONE_ZERO_LAST))
    else $error("tone half period does not match tx level");

  a_tx_on_640: assert property ( // see [R3]
    $changed(serial_tx_line_o) |-> $rose(clk_640_o))
    else $error("tx line moved off the 640 Hz edge");

  a_strobe_code: assert property ( // see [R8]
    !latch_strobe_o |-> select_code_bits_o == 3'h0)
    else $error("select code shown outside the strobe");

  a_radio_backup: assert property ( // see [R19]
    st_reg.pend && st_reg.a_wr && st_reg.a_addr == ADDR_RADIO && !primary
      |=> $stable(st_reg.radio))
    else $error("radio setting changed in backup role");

  a_memreq_off: assert property ( // see [R13]
    !st_reg.ctrl[CTRL_MEMREQ] |=> mem_request_n_o)
    else $error("memory request pulses while disabled");

  a_display_edge: assert property ( // see [R4]
    $changed(display_data_o) |-> !display_clk_o ##1 !display_clk_o)
    else $error("display data moved while shift clock high");

endmodule

//--- verification/radio_cm_far_side.sv
/*
  Far-side model: radio set, tandem unit, role line and panel.
  Assumes the bench sets carrier, role, panel and idle bus values.
*/
`timescale 1ns/10ps
module radio_cm_far_side
(
  input wire logic clk_sys_i,
  input wire logic carrier_on_i,
  input wire logic primary_i,
  input wire logic [7:0] panel_i,
  input wire logic [7:0] bus_idle_i,
  input wire logic serial_tx_line_i,
  input wire logic [7:0] dbus_o_i,
  input wire logic dbus_oe_n_i,
  output logic carrier_detect_n_o,
  output logic radio_rx_data_o,
  output logic tandem_rx_data_o,
  output logic main_standby_o,
  output logic [7:0] panel_switch_o,
  output logic [7:0] dbus_wire_o
);
  logic [16:0] bit_cnt = 17'h00000;
  logic rx_bit = 1'b0;

  // 640 Hz bit stream under carrier; no stale level when silent
  always @(posedge clk_sys_i)
  begin
    bit_cnt <= (bit_cnt == 17'h1312C) ? 17'h00000 : bit_cnt + 17'h00001;
    if (!carrier_on_i || bit_cnt == 17'h00000)
      rx_bit <= ~rx_bit;
  end

  // carrier flag follows the tone
  assign carrier_detect_n_o = ~carrier_on_i;
  assign radio_rx_data_o = rx_bit;
  // tandem unit echoes the line back
  assign tandem_rx_data_o = serial_tx_line_i;
  assign main_standby_o = primary_i;
  assign panel_switch_o = panel_i;
  // resolved bus: device wins while its enable is low
  assign dbus_wire_o = dbus_oe_n_i ? bus_idle_i : dbus_o_i;
endmodule

//--- verification/radio_control_monitor_timing_io_tb_top.sv
/*
  Bench for the timing and I/O unit: register rows over AHB-Lite,
  run-length monitor of pulse outputs, display, role and tone tests.
  Assumes the far-side model and a 50 MHz clock.
*/
`timescale 1ns/10ps
module radio_control_monitor_timing_io_tb_top
  import radio_cm_pkg::*;
();
  localparam int NS = 10;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic carrier_on = 1'b0;
  logic primary = 1'b1;
  logic [31:0] hrdata_o, rd;
  logic hreadyout_o, hresp_o, hready_i, carrier_detect_n_i;
  logic radio_rx_data_i, tandem_rx_data_i, main_standby_i;
  logic [7:0] panel_switch_i, dbus_i, dbus_o;
  logic [2:0] select_code_bits_o;
  logic dbus_oe_n_o, clk_1m92_o, clk_320k_o, clk_640_o, power_on_clear_n_o;
  logic transfer_tick_n_o, latch_strobe_o, mem_request_n_o, timing_pulse_a_o;
  logic timing_pulse_b_o, state_code0_o, state_code1_o, display_data_o;
  logic display_clk_o, serial_tx_line_o, tone_tx_data_o, promote_req_o;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  int run [NS];
  logic [NS-1:0] armed, prev, mon;
  logic [2:0] exp_code = 3'h5;
  logic [7:0] pat = 8'hB4;
  // run lengths in half ticks (3.84 MHz steps), low then high; 0 = free
  int half_t [NS][2] = '{'{1, 1}, '{6, 6}, '{3000, 3000}, '{6, 5984},
    '{0, 6}, '{14, 14}, '{10, 2}, '{10, 2}, '{5958, 32}, '{750, 750}};
  string nm [NS] = '{"clk_1m92", "clk_320k", "clk_640", "transfer_tick_n",
    "latch_strobe", "mem_request_n", "timing_pulse_a", "timing_pulse_b",
    "state_code1", "tone_tx_data"};
  typedef struct {logic [7:0] a; logic w; logic [31:0] d;
    logic [31:0] e;} row_t;
  // address, write?, write data, value read back
  row_t rows [7] = '{
    '{ADDR_CTRL, 1'b0, 32'h0, {26'h0, CTRL_RST}},
    '{ADDR_RADIO, 1'b0, 32'h0, {24'h0, RADIO_RST}},
    '{ADDR_CTRL, 1'b1, 32'hFFFFFFFD, 32'h3D},
    '{ADDR_RADIO, 1'b1, 32'h1A5, 32'hA5},
    '{8'h1C, 1'b1, 32'h55, 32'h0},
    '{ADDR_BUS, 1'b0, 32'h0, 32'hA5},
    '{ADDR_STROBE, 1'b1, 32'h5, 32'h5}};

  assign hready_i = hreadyout_o;
  assign mon = {tone_tx_data_o, state_code1_o, timing_pulse_b_o,
    timing_pulse_a_o, mem_request_n_o, latch_strobe_o, transfer_tick_n_o,
    clk_640_o, clk_320k_o, clk_1m92_o};

  always #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) cyc++;

  radio_cm_timing #(.CLEAR_TICKS(20)) dut (.*);

  radio_cm_far_side far (.clk_sys_i(clk_sys_i), .carrier_on_i(carrier_on),
    .primary_i(primary), .panel_i(8'h3C), .bus_idle_i(8'h96),
    .serial_tx_line_i(serial_tx_line_o), .dbus_o_i(dbus_o),
    .dbus_oe_n_i(dbus_oe_n_o), .carrier_detect_n_o(carrier_detect_n_i),
    .radio_rx_data_o(radio_rx_data_i), .tandem_rx_data_o(tandem_rx_data_i),
    .main_standby_o(main_standby_i), .panel_switch_o(panel_switch_i),
    .dbus_wire_o(dbus_i));

  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask

  // clocks counted against nominal, slack for edge quantisation
  task automatic chk_rng(input string s, input int g, input int h,
    input int sl);
    int nom = h * CLK_KHZ / XTAL_KHZ;
    n_checks++;
    if (g < nom - 1 || g > nom + sl)
    begin
      fail_count++;
      $display("unexpected %s expected %0d seen %0d", s, nom, g);
    end
  endtask

  // no cycle limit here: only the watchdog may end a stalled transfer
  task automatic wait_ready;
    do
    begin
      @(posedge clk_sys_i);
    end
    while (hreadyout_o !== 1'b1);
  endtask

  // one single-word transfer; read data lands in rd
  task automatic xfer(input logic [7:0] a, input logic w,
    input logic [31:0] wd);
    hsel_i <= 1'b1;
    haddr_i <= {24'h000000, a};
    htrans_i <= 2'h2;
    hwrite_i <= w;
    wait_ready();
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= wd;
    wait_ready();
    rd = hrdata_o;
  endtask

  task print_verdict;
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // every run of a pulse output not marked free is checked once a first edge was seen
  always @(posedge clk_sys_i)
  begin
    for (int k = 0; k < NS; k++)
    begin
      if (srst_i)
        armed[k] = 1'b0;
      else if (mon[k] !== prev[k])
      begin
        if (armed[k] && half_t[k][prev[k]] != 0)
          chk_rng(nm[k], run[k],
            half_t[k][prev[k]], 2);
        armed[k] = 1'b1;
        run[k] = 0;
      end
      run[k]++;
    end
    prev = mon;
    if (latch_strobe_o === 1'b1)
      chk("select_code_bits", 32'(exp_code),
        32'(select_code_bits_o));
    chk("display_clk", 32'(clk_320k_o), 32'(display_clk_o));
  end

  // watchdog, past the 86000-cycle run and under the cycle budget
  initial
  begin
    repeat (95000) @(posedge clk_sys_i);
    fail_count++;
    print_verdict();
  end

  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    chk("reset outputs", 32'h6,
      {29'h0, hreadyout_o, dbus_oe_n_o, power_on_clear_n_o});
    srst_i <= 1'b0;
    n = 0;
    while (power_on_clear_n_o !== 1'b1 && n < 2000)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    // first tick after reset comes about half a tick early
    chk_rng("power_on_clear", n, 39, 30);
    foreach (rows[i])
    begin
      if (rows[i].w)
        xfer(rows[i].a, 1'b1, rows[i].d);
      xfer(rows[i].a, 1'b0, 32'h0);
      chk("register", rows[i].e, rd);
    end
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    chk("status", 32'h19, rd & 32'h1D);
    carrier_on <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    chk("status", 32'h18, rd & 32'h1D);
    chk("radio_rx", 32'(radio_rx_data_i), 32'(rd[1]));
    // display: bits msb first, sampled on the shift clock rise
    xfer(ADDR_DISPLAY, 1'b1, 32'hB4);
    @(negedge display_clk_o);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge display_clk_o);
      chk("display_data", 32'(pat[i]), 32'(display_data_o));
    end
    @(posedge clk_sys_i);
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    chk("display busy", 32'h20, rd & 32'h20);
    // a load while busy must leave the emptied shift register alone
    xfer(ADDR_DISPLAY, 1'b1, 32'hFF);
    xfer(ADDR_DISPLAY, 1'b0, 32'h0);
    chk("display refused", 32'h0, rd);
    n = 0;
    do
    begin
      xfer(ADDR_STATUS, 1'b0, 32'h0);
      n++;
    end
    while (rd[5] !== 1'b0 && n < 200);
    xfer(ADDR_DISPLAY, 1'b0, 32'h0);
    chk("display remaining", 32'h0, rd);
    // tx bit only reaches the line at a 640 Hz rise
    n = 0;
    while (serial_tx_line_o !== 1'b1 && n < 45000)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    chk("serial_tx_line", 32'h1, 32'(serial_tx_line_o));
    repeat (5) @(posedge clk_sys_i);
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    chk("status", 32'h1C, rd & 32'h1D);
    xfer(ADDR_SWITCH, 1'b0, 32'h0);
    chk("switches", 32'h3C, rd);
    xfer(ADDR_CTRL, 1'b1, 32'h3F);
    // backup role: read-only radio settings, bus released
    primary <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    chk("promote_req", 32'h1, 32'(promote_req_o));
    xfer(ADDR_RADIO, 1'b1, 32'h11);
    xfer(ADDR_RADIO, 1'b0, 32'h0);
    chk("radio in backup", 32'hA5, rd);
    repeat (5) @(posedge clk_sys_i);
    xfer(ADDR_BUS, 1'b0, 32'h0);
    chk("bus in", 32'h96, rd);
    chk("dbus_oe_n", 32'h1, 32'(dbus_oe_n_o));
    chk("state_code0", 32'h1, 32'(state_code0_o));
    // let tone halves and one whole frame be measured
    while (cyc < 86000)
      @(posedge clk_sys_i);
    chk("hresp", 32'h0, 32'(hresp_o));
    print_verdict();
  end
endmodule
